// >>> hdl/asc_pkg.sv
/*
 * Constants shared by the amplifier status and configuration register bank:
 * register offsets, field positions, reset values and format codes.
 * Assumes a 32-bit APB register bus with byte addresses four times the index.
 */
package asc_pkg;

    // ------------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------------
    localparam logic [7:0]  ASC_IDX_CLK_CTRL = 8'h00;
    localparam logic [7:0]  ASC_IDX_IDENT    = 8'h01;
    localparam logic [7:0]  ASC_IDX_ERR      = 8'h02;
    localparam logic [7:0]  ASC_IDX_SYS1     = 8'h03;
    localparam logic [7:0]  ASC_IDX_FMT      = 8'h04;
    localparam logic [11:0] ASC_ADR_CLK_CTRL = {2'h0, ASC_IDX_CLK_CTRL, 2'h0};
    localparam logic [11:0] ASC_ADR_IDENT    = {2'h0, ASC_IDX_IDENT, 2'h0};
    localparam logic [11:0] ASC_ADR_ERR      = {2'h0, ASC_IDX_ERR, 2'h0};
    localparam logic [11:0] ASC_ADR_SYS1     = {2'h0, ASC_IDX_SYS1, 2'h0};
    localparam logic [11:0] ASC_ADR_FMT      = {2'h0, ASC_IDX_FMT, 2'h0};

    // ------------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------------
    localparam int ASC_ERR_MCLK   = 7;
    localparam int ASC_ERR_PLL    = 6;
    localparam int ASC_ERR_SCLK   = 5;
    localparam int ASC_ERR_LRCLK  = 4;
    localparam int ASC_ERR_SLIP   = 3;
    localparam int ASC_SYS1_DCBLK = 7;
    localparam int ASC_SYS1_HARD  = 5;
    localparam int ASC_SYS1_NOAD  = 3;
    localparam int ASC_SYS1_NOSS  = 2;
    localparam int ASC_CLK_SCLK48 = 1;
    localparam int ASC_CLK_VALID  = 0;

    // ------------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------------
    localparam logic [7:0] ASC_ERR_RST      = 8'h00;
    localparam logic [7:0] ASC_ERR_MASK     = 8'hf8;
    localparam logic [7:0] ASC_SYS1_RST     = 8'ha0;
    localparam logic [7:0] ASC_SYS1_MASK    = 8'haf;
    localparam logic [7:0] ASC_FMT_RST      = 8'h05;
    localparam logic [7:0] ASC_FMT_MASK     = 8'h1f;
    localparam logic [7:0] ASC_CLK_RST      = 8'h6c;
    localparam logic [6:0] ASC_IDENT_DEF    = 7'h11;  // Arbitrary value.
    localparam int         ASC_SYNC_STAGES  = 2;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {ASC_RJ, ASC_I2S, ASC_LJ, ASC_BAD} asc_fmt_t;
    typedef enum logic [1:0] {ASC_DE_NONE, ASC_DE_RSVD, ASC_DE_441, ASC_DE_48} asc_deemph_t;

endpackage

// >>> hdl/asc_sync.sv
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the input has no relation to clk_sys.
 */
`timescale 1ns/10ps
module asc_sync
    import asc_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Level
    input  wire logic async_in,
    output logic      sync_out
);

    logic [ASC_SYNC_STAGES-1:0] stage_r;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage_r <= '0;
        end else begin
            stage_r <= {stage_r[ASC_SYNC_STAGES-2:0], async_in};
        end
    end

    assign sync_out = stage_r[ASC_SYNC_STAGES-1];

endmodule

// >>> hdl/asc_fmt_decode.sv
/*
 * Decodes the serial input format code into format, word length and bit-clock ratio.
 * Assumes a registered code from the same clock domain; purely combinational.
 */
`timescale 1ns/10ps
module asc_fmt_decode
    import asc_pkg::*;
(
    // Code in
    input  wire logic [4:0] code,
    // Decoded format
    output asc_fmt_t        fmt,
    output logic [4:0]      word_len,
    output logic            bclk32,
    output logic            legal
);

    always_comb begin
        fmt      = ASC_BAD;
        word_len = 5'd0;
        bclk32   = 1'b0;
        legal    = 1'b1;
        unique case (code)
            5'h00: begin fmt = ASC_RJ;  word_len = 5'd16; end
            5'h01: begin fmt = ASC_RJ;  word_len = 5'd20; end
            5'h02: begin fmt = ASC_RJ;  word_len = 5'd24; end
            5'h0a: begin fmt = ASC_RJ;  word_len = 5'd18; end
            5'h03: begin fmt = ASC_I2S; word_len = 5'd16; end
            5'h04: begin fmt = ASC_I2S; word_len = 5'd20; end
            5'h05: begin fmt = ASC_I2S; word_len = 5'd24; end
            5'h06: begin fmt = ASC_LJ;  word_len = 5'd16; end
            5'h07: begin fmt = ASC_LJ;  word_len = 5'd20; end
            5'h08: begin fmt = ASC_LJ;  word_len = 5'd24; end
            5'h13: begin fmt = ASC_I2S; word_len = 5'd16; bclk32 = 1'b1; end
            5'h16: begin fmt = ASC_LJ;  word_len = 5'd16; bclk32 = 1'b1; end
            default: legal = 1'b0;
        endcase
    end

endmodule

// >>> hdl/asc_regs.sv
/*
 * Status and configuration register bank of the audio amplifier: identification,
 * sticky clock-error flags, system control one, serial input format and the
 * clock control register it steers. Registers sit behind an APB slave.
 * Assumes clock-monitor error inputs and detected-rate inputs arrive
 * asynchronously and are synchronised here; the audio_processor_core reads the
 * configuration outputs on clk_sys.
 */
// The APB register port was decided locally.
`timescale 1ns/10ps

// Notes on behaviour
// R1: Read-only identification at 0x01, top bit reads zero.
// R2: Error flags stick until a host write clears them; reset value zero.
// R3: Host clears error register with zeros, then reads back for persistent errors.
// R4: PLL autolock D6, bit clock D5, frame clock D4, frame slip D3.
// R5: Master-clock error flag sits in D7.
// R6: System control D7 enables dc-blocking high-pass; default enabled.
// R7: System control D5 picks hard (1, default) or soft unmute after clock error.
// R8: System control D3 clear enables clock autodetect (default).
// R9: Autodetect reports rates in clock control; manual mode needs valid bit.
// R10: System control D2 clear enables soft start (default).
// R11: System control D1-D0 select de-emphasis none, reserved, 44.1 or 48 kHz.
// R12: Format register resets to code 00101, 24-bit I2S.
// R13: Right-justified and I2S format codes decode to their word lengths.
// R14: Left-justified codes and the two 32-fs bit-clock codes decode.
// R15: With non-48-fs bit clock, 32 or 64 fs follows the format code.
// R16: Host leaves reserved codes and bits at zero.
module asc_regs
    import asc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Clock monitor events, asynchronous levels
    input  wire logic        mclk_err_in,
    input  wire logic        pll_err_in,
    input  wire logic        sclk_err_in,
    input  wire logic        lrclk_err_in,
    input  wire logic        slip_in,
    // Detected clock rates, asynchronous
    input  wire logic [2:0]  det_rate_in,
    input  wire logic [2:0]  det_mclk_in,
    // Configuration to the audio_processor_core
    output logic             dc_block_en,
    output logic             hard_unmute,
    output logic             autodetect_en,
    output logic             soft_start_en,
    output asc_deemph_t      deemph_sel,
    output asc_fmt_t         fmt_sel,
    output logic [4:0]       word_len,
    output logic             bclk32_sel,
    output logic             bclk48_sel,
    output logic             clk_valid
);

    // ------------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------------
    logic [4:0] ev_async;
    logic [4:0] ev_sync;
    logic [5:0] det_async;
    logic [5:0] det_sync;

    assign ev_async  = {mclk_err_in, pll_err_in, sclk_err_in, lrclk_err_in, slip_in};
    assign det_async = {det_rate_in, det_mclk_in};

    // Every bit gets its own synchroniser; the rate word as a whole is qualified further down.
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_sync
            if (gi < 5) begin : g_ev
                asc_sync u_sync (
                    .clk_sys  (clk_sys),
                    .nrst     (nrst),
                    .async_in (ev_async[gi]),
                    .sync_out (ev_sync[gi])
                );
            end else begin : g_det
                asc_sync u_sync (
                    .clk_sys  (clk_sys),
                    .nrst     (nrst),
                    .async_in (det_async[gi-5]),
                    .sync_out (det_sync[gi-5])
                );
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic       acc_w;
    logic       wr_w;
    logic       hit_clk;
    logic       hit_id;
    logic       hit_err;
    logic       hit_sys;
    logic       hit_fmt;
    logic       hit_any;
    logic [7:0] wbyte;

    // A write lands only at the edge that completes the transfer, never in a stretched access.
    assign acc_w   = psel & penable & pready;
    assign wr_w    = acc_w & pwrite & pstrb[0];
    assign hit_clk = (paddr == ASC_ADR_CLK_CTRL);
    assign hit_id  = (paddr == ASC_ADR_IDENT);
    assign hit_err = (paddr == ASC_ADR_ERR);
    assign hit_sys = (paddr == ASC_ADR_SYS1);
    assign hit_fmt = (paddr == ASC_ADR_FMT);
    assign hit_any = hit_clk | hit_id | hit_err | hit_sys | hit_fmt;
    assign wbyte   = pwdata[7:0];

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] err_r;
    logic [7:0] err_nxt;
    logic [7:0] err_set;
    logic [7:0] sys1_r;
    logic [7:0] fmt_r;
    logic [7:0] clk_r;
    logic [7:0] clk_nxt;
    logic [7:0] ident_w;
    logic [5:0] det_last_r;
    logic       det_ok;

    assign ident_w = {1'b0, ASC_IDENT_DEF};  // R1
    assign err_set = {ev_sync[4], ev_sync[3], ev_sync[2], ev_sync[1], ev_sync[0], 3'h0};  // R4 R5
    // A set in the cycle of a clearing write wins, so no event is lost.
    assign err_nxt = ((wr_w & hit_err) ? (wbyte & err_r & ASC_ERR_MASK) : err_r) | err_set;  // R2

    // The rate word crosses bit by bit, so it is taken only after two equal samples;
    // a word caught mid-change never reaches the register.
    assign det_ok  = (det_sync == det_last_r);

    // In autodetect the rate fields follow the monitor; the host keeps D1 and D0.
    assign clk_nxt = sys1_r[ASC_SYS1_NOAD]
                   ? ((wr_w & hit_clk) ? wbyte : clk_r)
                   : {(det_ok ? det_sync : clk_r[7:2]), ((wr_w & hit_clk) ? wbyte[1:0] : clk_r[1:0])};  // R9

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            err_r  <= ASC_ERR_RST;
            sys1_r <= ASC_SYS1_RST;
            fmt_r  <= ASC_FMT_RST;  // R12
            clk_r  <= ASC_CLK_RST;
            det_last_r <= 6'h00;
        end else begin
            err_r  <= err_nxt;
            clk_r  <= clk_nxt;
            det_last_r <= det_sync;
            if (wr_w & hit_sys) begin
                sys1_r <= wbyte & ASC_SYS1_MASK;  // R16
            end
            if (wr_w & hit_fmt) begin
                fmt_r <= wbyte & ASC_FMT_MASK;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read data and answer
    // ------------------------------------------------------------------------
    logic [7:0] rsel;

    assign rsel = hit_clk ? clk_r :
                  hit_id  ? ident_w :
                  hit_err ? err_r :
                  hit_sys ? sys1_r :
                  hit_fmt ? fmt_r : 8'h00;

    // Answer in the first access cycle: pready is a flop set by the setup cycle.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rsel} : 32'h0000_0000;
            pslverr <= psel & ~penable & (~hit_any | (pwrite & hit_id));
        end
    end

    // ------------------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------------------
    asc_fmt_t   fmt_w;
    logic [4:0] len_w;
    logic       b32_w;

    asc_fmt_decode u_dec (
        .code     (fmt_r[4:0]),
        .fmt      (fmt_w),
        .word_len (len_w),
        .bclk32   (b32_w),
        .legal    ()
    );  // R13 R14

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dc_block_en   <= ASC_SYS1_RST[ASC_SYS1_DCBLK];
            hard_unmute   <= ASC_SYS1_RST[ASC_SYS1_HARD];
            autodetect_en <= ~ASC_SYS1_RST[ASC_SYS1_NOAD];
            soft_start_en <= ~ASC_SYS1_RST[ASC_SYS1_NOSS];
            deemph_sel    <= asc_deemph_t'(ASC_SYS1_RST[1:0]);
            fmt_sel       <= ASC_I2S;
            word_len      <= 5'd24;
            bclk32_sel    <= 1'b0;
            bclk48_sel    <= 1'b0;
            clk_valid     <= 1'b0;
        end else begin
            dc_block_en   <= sys1_r[ASC_SYS1_DCBLK];   // R6
            hard_unmute   <= sys1_r[ASC_SYS1_HARD];    // R7
            autodetect_en <= ~sys1_r[ASC_SYS1_NOAD];   // R8
            soft_start_en <= ~sys1_r[ASC_SYS1_NOSS];   // R10
            deemph_sel    <= asc_deemph_t'(sys1_r[1:0]); // R11
            fmt_sel       <= fmt_w;
            word_len      <= len_w;
            bclk48_sel    <= clk_r[ASC_CLK_SCLK48];
            bclk32_sel    <= ~clk_r[ASC_CLK_SCLK48] & b32_w;  // R15
            clk_valid     <= ~sys1_r[ASC_SYS1_NOAD] | clk_r[ASC_CLK_VALID];  // R9
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence

    apb_answer_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R1
        s_setup |=> pready)
        else $error("APB access not answered in one cycle");
    ident_top_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R1
        (s_setup and hit_id and !pwrite) |=> prdata == {24'h0, 1'b0, ASC_IDENT_DEF})
        else $error("identification read wrong");
    err_sticky_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R2
        !(wr_w && hit_err) |=> (err_r & $past(err_r)) == $past(err_r))
        else $error("error flag dropped without a write");
    err_catch_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R4
        ev_sync[3] |=> err_r[ASC_ERR_PLL])
        else $error("PLL error not flagged");
    err_mclk_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R5
        ev_sync[4] |=> err_r[ASC_ERR_MCLK])
        else $error("master clock error not flagged");
    err_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R2
        err_r[2:0] == 3'h0)
        else $error("unused error bits set");
    dc_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R6
        (wr_w && hit_sys) |=> ##1 dc_block_en == $past(wbyte[ASC_SYS1_DCBLK], 2))
        else $error("dc block enable not following write");
    soft_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R10
        (wr_w && hit_sys) |=> ##1 soft_start_en == !$past(wbyte[ASC_SYS1_NOSS], 2))
        else $error("soft start enable wrong");
    bclk_sel_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R15
        bclk32_sel |-> !bclk48_sel)
        else $error("both bit clock ratios selected");

    // Writes are named steps so the unmute, autodetect and de-emphasis follow checks read as write, settle, compare.
    sequence s_sys_wr;
        wr_w && hit_sys;
    endsequence

    sequence s_err_clr;
        wr_w && hit_err && (wbyte == 8'h00) && (ev_sync == 5'h00);
    endsequence

    hard_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R7
        s_sys_wr |=> ##1 hard_unmute == $past(wbyte[ASC_SYS1_HARD], 2))
        else $error("unmute style not following write");
    auto_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R8
        s_sys_wr |=> ##1 autodetect_en == !$past(wbyte[ASC_SYS1_NOAD], 2))
        else $error("autodetect enable wrong");
    deemph_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R11
        s_sys_wr |=> ##1 deemph_sel == $past(wbyte[1:0], 2))
        else $error("de-emphasis select wrong");
    err_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R2
        s_err_clr |=> err_r == 8'h00)
        else $error("error register not cleared by zeros");
    err_sclk_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R4
        ev_sync[2] |=> err_r[ASC_ERR_SCLK])
        else $error("bit clock error not flagged");
    err_lrclk_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R4
        ev_sync[1] |=> err_r[ASC_ERR_LRCLK])
        else $error("frame clock error not flagged");
    err_slip_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R4
        ev_sync[0] |=> err_r[ASC_ERR_SLIP])
        else $error("frame slip not flagged");
    ident_refuse_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R1
        (psel && !penable && hit_id && pwrite) |=> pslverr)
        else $error("identification write not refused");
    rate_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R9
        (!sys1_r[ASC_SYS1_NOAD] && det_ok) |=> clk_r[7:2] == $past(det_sync))
        else $error("detected rates not reported");
    auto_valid_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R9
        !sys1_r[ASC_SYS1_NOAD] |=> clk_valid)
        else $error("clock not valid in autodetect");
    len_rj18_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R13
        (fmt_r[4:0] == 5'h0a) |=> word_len == 5'h12)
        else $error("right-justified 18-bit word length wrong");
    lj32_sel_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R14 R15
        (!clk_r[ASC_CLK_SCLK48] && fmt_r[4:0] == 5'h16) |=> (bclk32_sel && fmt_sel == ASC_LJ))
        else $error("32-fs left-justified not selected");
    fmt_top_a: assert property (@(posedge clk_sys) disable iff (!nrst)  // R16
        fmt_r[7:5] == 3'h0)
        else $error("format reserved bits set");

endmodule

// >>> verification/asc_regs_tb_top.sv
/*
 * Self-checking testbench of the amplifier status and configuration register bank.
 * Assumes the bank's own assertions sit in the design files and that the bench
 * is the only APB master and the only source of clock-monitor events.
 */
`timescale 1ns/10ps
module asc_regs_tb_top
    import asc_pkg::*;
();
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [4:0]  ev, word_len;
    logic [2:0]  det_rate, det_mclk;
    logic        dc_block_en, hard_unmute, autodetect_en, soft_start_en, bclk32_sel, bclk48_sel, clk_valid;
    asc_deemph_t deemph_sel;
    asc_fmt_t    fmt_sel;
    int          bad_count, checks;
    logic [4:0]  f_code [13] = '{5'h00, 5'h01, 5'h02, 5'h0a, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
                                 5'h13, 5'h16, 5'h09};
    asc_fmt_t    f_fmt [13] = '{ASC_RJ, ASC_RJ, ASC_RJ, ASC_RJ, ASC_I2S, ASC_I2S, ASC_I2S, ASC_LJ, ASC_LJ,
                                ASC_LJ, ASC_I2S, ASC_LJ, ASC_BAD};
    logic [4:0]  f_wl [13] = '{5'h10, 5'h14, 5'h18, 5'h12, 5'h10, 5'h14, 5'h18, 5'h10, 5'h14, 5'h18,
                               5'h10, 5'h00, 5'h00};
    logic [7:0]  s_val [5] = '{8'h00, 8'h8d, 8'h26, 8'hab, 8'ha0};

    asc_regs u_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mclk_err_in(ev[4]), .pll_err_in(ev[3]), .sclk_err_in(ev[2]), .lrclk_err_in(ev[1]), .slip_in(ev[0]),
        .det_rate_in(det_rate), .det_mclk_in(det_mclk), .dc_block_en(dc_block_en), .hard_unmute(hard_unmute),
        .autodetect_en(autodetect_en), .soft_start_en(soft_start_en), .deemph_sel(deemph_sel),
        .fmt_sel(fmt_sel), .word_len(word_len), .bclk32_sel(bclk32_sel), .bclk48_sel(bclk48_sel),
        .clk_valid(clk_valid));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    // Outputs are read just after an edge, before that edge's updates land.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= adr;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        chk(n, 1, "answer latency");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] adr, input logic [7:0] exp, input string msg);
        apb(1'b0, adr, 32'h0);
        chk({err, rd}, {1'b0, 24'h0, exp}, msg);
    endtask

    task automatic conclude();
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        nrst <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        cyc(3);
        chk({dc_block_en, hard_unmute, autodetect_en, soft_start_en, deemph_sel}, 6'b111100, "ctrl");
        chk({fmt_sel, word_len, bclk32_sel, clk_valid}, {ASC_I2S, 5'd24, 2'b01}, "fmt");
        rchk(ASC_ADR_IDENT, {1'b0, ASC_IDENT_DEF}, "ident");
        rchk(ASC_ADR_ERR, 8'h00, "err");
        rchk(ASC_ADR_SYS1, 8'ha0, "sys1");
        rchk(ASC_ADR_FMT, 8'h05, "fmt reg");
    endtask

    task automatic t_refuse();
        apb(1'b1, ASC_ADR_IDENT, 32'h7f);
        chk(err, 1'b1, "ident write");
        rchk(ASC_ADR_IDENT, {1'b0, ASC_IDENT_DEF}, "ident kept");
        apb(1'b0, 12'h0fc, 32'h0);
        chk({err, rd}, {1'b1, 32'h0}, "unmapped");
        pstrb <= 4'h0;
        apb(1'b1, ASC_ADR_SYS1, 32'h0);
        pstrb <= 4'h1;
        rchk(ASC_ADR_SYS1, 8'ha0, "no strobe");
    endtask

    task automatic t_sticky();
        for (int i = 0; i < 5; i++) begin
            ev[i] <= 1'b1;
            cyc(4);
            ev[i] <= 1'b0;
            cyc(5);
            rchk(ASC_ADR_ERR, 8'h08 << i, "flag held");
            apb(1'b1, ASC_ADR_ERR, 32'h0);
            rchk(ASC_ADR_ERR, 8'h00, "flag cleared");
        end
        ev[3] <= 1'b1;
        cyc(5);
        apb(1'b1, ASC_ADR_ERR, 32'h0);
        rchk(ASC_ADR_ERR, 8'h40, "persistent");
        ev[3] <= 1'b0;
        cyc(5);
        apb(1'b1, ASC_ADR_ERR, 32'h0);
        apb(1'b1, ASC_ADR_ERR, 32'hf8);
        rchk(ASC_ADR_ERR, 8'h00, "ones set nothing");
    endtask

    task automatic t_sys1();
        logic [7:0] v;
        for (int i = 0; i < 5; i++) begin
            v = s_val[i];
            apb(1'b1, ASC_ADR_SYS1, {24'h0, v});
            cyc(2);
            chk({dc_block_en, hard_unmute, autodetect_en, soft_start_en, deemph_sel},
                {v[7], v[5], ~v[3], ~v[2], v[1:0]}, "ctrl");
            rchk(ASC_ADR_SYS1, v, "sys1 back");
        end
        apb(1'b1, ASC_ADR_SYS1, 32'hff);
        rchk(ASC_ADR_SYS1, 8'haf, "reserved zero");
        apb(1'b1, ASC_ADR_SYS1, 32'ha0);
    endtask

    task automatic t_fmt();
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, ASC_ADR_FMT, {27'h0, f_code[i]});
            cyc(2);
            chk({fmt_sel, bclk32_sel}, {f_fmt[i], i == 10 || i == 11}, "format");
            if (i != 11) begin
                chk(word_len, f_wl[i], "word length");
            end
        end
        apb(1'b1, ASC_ADR_FMT, 32'hf3);
        rchk(ASC_ADR_FMT, 8'h13, "fmt reserved");
    endtask

    task automatic t_clk();
        det_rate <= 3'h5;
        det_mclk <= 3'h2;
        cyc(6);
        rchk(ASC_ADR_CLK_CTRL, 8'ha8, "detected");
        chk(clk_valid, 1'b1, "auto valid");
        apb(1'b1, ASC_ADR_CLK_CTRL, 32'hff);
        cyc(2);
        chk({bclk48_sel, bclk32_sel}, 2'b10, "sclk 48");
        rchk(ASC_ADR_CLK_CTRL, 8'hab, "auto low bits");
        apb(1'b1, ASC_ADR_SYS1, 32'ha8);
        apb(1'b1, ASC_ADR_CLK_CTRL, 32'h60);
        cyc(2);
        chk({autodetect_en, clk_valid, bclk48_sel, bclk32_sel}, 4'b0001, "manual");
        rchk(ASC_ADR_CLK_CTRL, 8'h60, "manual rates");
        apb(1'b1, ASC_ADR_CLK_CTRL, 32'h61);
        cyc(2);
        chk(clk_valid, 1'b1, "manual valid");
    endtask

    // ------------------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata, ev, det_rate, det_mclk} = '0;
        pstrb     = 4'h1;
        bad_count = 0;
        checks    = 0;
        t_reset();
        t_refuse();
        t_sticky();
        t_sys1();
        t_fmt();
        t_clk();
        t_reset();
        conclude();
    end

    // The full sequence takes well under a thousand cycles.
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule
